// [hw/srap_ctrl.sv]
// sample pacing, averaging and timed shutdown controller
// Summary of operation
// - all seven words captured together and refreshed each period, read or not
// - period bit 7 picks 122.1 us unit when clear, 3.784 ms when set
// - period equals low seven-bit count plus one, times the unit
// - period setting comes up as 4, short unit, about 610 us
// - period setting survives reset through the nonvolatile store
// - filter length is two to the power of the depth setting
// - depth field is four bits, at most 8; upper bits unused
// - each tap weighs one over the tap count, unity gain
// - one filter depth applies to all seven words alike
// - depth setting comes up as 4, sixteen samples
// - shutdown lasts the eight-bit count times half a second
// - shutdown count reads zero after power-up and after every wake
// - nonzero count: finish period, update words, then shut down
// - shutdown ends only by timeout, reset line or power cycle
// - after timeout wait about 2 ms before the next conversion
// - entering shutdown clears new-data flags and the new-data pin
// - output converter powered down, at 0 V, during shutdown
// - settings kept through shutdown; count cleared on the same edge that it starts
// - output words keep their last values through shutdown
// - count of zero keeps continuous acquisition
// - alarms see raw samples, not averaged ones
`timescale 1ns/1ns
module srap_ctrl #(
    parameter int LONG_UNIT_CYC = srap_pkg::LONG_UNIT_CYC,
    parameter int HALF_SEC_CYC = srap_pkg::HALF_SEC_CYC,
    parameter int RECOVER_CYC = srap_pkg::RECOVER_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [15:0] reg_rd_data,
    input wire logic [7:0] nv_period_cfg,
    input wire logic [3:0] nv_avg_cfg,
    output logic [7:0] sample_period_setting,
    output logic [3:0] average_depth_setting,
    input wire logic [srap_pkg::NUM_WORDS*srap_pkg::WORD_W-1:0] raw_data,
    output logic sample_strobe,
    output logic [srap_pkg::NUM_WORDS*srap_pkg::WORD_W-1:0] alarm_data,
    output logic alarm_strobe,
    output logic [srap_pkg::NUM_WORDS*srap_pkg::WORD_W-1:0] out_data,
    output logic [srap_pkg::NUM_WORDS-1:0] new_sample_flag,
    input wire logic [srap_pkg::NUM_WORDS-1:0] word_read,
    output logic new_data_pin,
    output logic dac_powerdown,
    output logic acquiring
);
    import srap_pkg::*;

    localparam int DW = NUM_WORDS * WORD_W;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    srap_tick_if tk ();

    srap_state_t state_q;
    logic [7:0] period_q;
    logic [3:0] avg_q;
    logic [7:0] pd_q;
    logic [7:0] remain_q;
    logic [31:0] recov_q;
    logic restore_q;
    logic period_chg_q;
    logic avg_chg_q;
    logic cap_q;
    logic [DW-1:0] raw_q;
    logic [DW-1:0] data_q;
    logic [NUM_WORDS-1:0] flag_q;
    logic [15:0] rd_q;
    logic [15:0] rd_d;
    logic filt_valid;
    logic [DW-1:0] filt_data;
    logic upd;
    logic enter_sd;
    logic wr_ok;
    srap_sel_t wsel;

    function automatic srap_sel_t decode(input logic [6:0] addr);
        case ({addr[6:1], 1'b0})
            ADDR_PERIOD: decode = SEL_PERIOD;
            ADDR_AVG: decode = SEL_AVG;
            ADDR_PD: decode = SEL_PD;
            default: decode = SEL_NONE;
        endcase
    endfunction

    srap_timebase #(
        .LONG_UNIT_CYC(LONG_UNIT_CYC),
        .HALF_SEC_CYC(HALF_SEC_CYC)
    ) u_tb (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tk(tk.tb)
    );

    srap_avg #(
        .CH(NUM_WORDS),
        .W(WORD_W),
        .LOG_MAX(AVG_LOG_MAX)
    ) u_avg (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .restart(avg_chg_q),
        .depth(avg_q),
        .in_valid(cap_q),
        .in_data(raw_q),
        .out_valid(filt_valid),
        .out_data(filt_data)
    );

    assign tk.ce = ce;
    assign tk.run = (state_q == ST_ACQ);
    assign tk.restart = period_chg_q || restore_q;
    assign tk.long_base = period_q[TB_SEL_BIT];
    assign tk.period_count = period_q[CNT_MSB:0];
    assign tk.half_run = (state_q == ST_SHUTDOWN);

    assign upd = filt_valid && (state_q == ST_ACQ);
    assign enter_sd = upd && (pd_q != 8'h00);
    assign wr_ok = ce && reg_wr_en && !restore_q;
    assign wsel = decode(reg_addr);

    assign sample_strobe = tk.period_tick && ce && (state_q == ST_ACQ);
    assign alarm_data = raw_q;
    assign alarm_strobe = cap_q;
    assign out_data = data_q;
    assign new_sample_flag = flag_q;
    assign reg_rd_data = rd_q;
    assign sample_period_setting = period_q;
    assign average_depth_setting = avg_q;
    assign acquiring = (state_q == ST_ACQ);
    assign new_data_pin = (|flag_q) && (state_q == ST_ACQ);
    assign dac_powerdown = (state_q != ST_ACQ);

    // nonvolatile settings are reloaded from the store one cycle after reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            restore_q <= 1'b1;
            period_q <= PERIOD_RST;
            avg_q <= AVG_RST;
            period_chg_q <= 1'b0;
            avg_chg_q <= 1'b1;
        end else if (ce) begin
            period_chg_q <= 1'b0;
            avg_chg_q <= 1'b0;
            if (restore_q) begin
                restore_q <= 1'b0;
                period_q <= nv_period_cfg;
                avg_q <= (nv_avg_cfg > AVG_MAX) ? AVG_MAX : nv_avg_cfg;
                avg_chg_q <= 1'b1;
            end else if (wr_ok && !reg_addr[0]) begin
                if (wsel == SEL_PERIOD) begin
                    period_q <= reg_wdata;
                    period_chg_q <= 1'b1;
                end
                if (wsel == SEL_AVG) begin
                    // out-of-range depths are clamped rather than ignored
                    avg_q <= (reg_wdata[AVG_MSB:0] > AVG_MAX) ? AVG_MAX
                             : reg_wdata[AVG_MSB:0];
                    avg_chg_q <= 1'b1;
                end
            end
        end
    end

    // shutdown count: volatile, cleared as the device powers down
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pd_q <= PD_RST;
        end else if (ce) begin
            if (enter_sd) begin
                pd_q <= PD_RST;
            end else if (wr_ok && !reg_addr[0] && wsel == SEL_PD
                         && state_q == ST_ACQ) begin
                pd_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_ACQ;
            remain_q <= 8'h00;
            recov_q <= 32'h00000000;
        end else if (ce) begin
            case (state_q)
                ST_ACQ: begin
                    if (enter_sd) begin
                        state_q <= ST_SHUTDOWN;
                        remain_q <= pd_q;
                    end
                end
                ST_SHUTDOWN: begin
                    // only the half-second tick or reset line leaves here
                    if (tk.half_tick) begin
                        if (remain_q == 8'h01) begin
                            state_q <= ST_RECOVER;
                            recov_q <= 32'(RECOVER_CYC - 1);
                        end
                        remain_q <= remain_q - 8'h01;
                    end
                end
                ST_RECOVER: begin
                    if (recov_q == 32'h00000000) begin
                        state_q <= ST_ACQ;
                    end else begin
                        recov_q <= recov_q - 32'h00000001;
                    end
                end
                default: begin
                    state_q <= ST_ACQ;
                end
            endcase
        end
    end

    // raw capture feeds both the alarm path and the filter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cap_q <= 1'b0;
            raw_q <= '0;
        end else if (ce) begin
            cap_q <= sample_strobe;
            if (sample_strobe) begin
                raw_q <= raw_data;
            end
        end
    end

    // words stay frozen outside acquisition so they can be read after wake
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_q <= '0;
        end else if (ce && upd) begin
            data_q <= filt_data;
        end
    end

    // new data beats a same-cycle host read; shutdown entry beats both
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= '0;
        end else if (ce) begin
            if (enter_sd) begin
                flag_q <= '0;
            end else if (upd) begin
                flag_q <= '1;
            end else begin
                flag_q <= flag_q & ~word_read;
            end
        end
    end

    always_comb begin
        rd_d = 16'h0000;
        case (decode(reg_addr))
            SEL_PERIOD: rd_d = {8'h00, period_q};
            SEL_AVG: rd_d = {12'h000, avg_q};
            SEL_PD: rd_d = {8'h00, pd_q};
            default: rd_d = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_q <= 16'h0000;
        end else if (ce && reg_rd_en) begin
            rd_q <= rd_d;
        end
    end

    AST_PD_CLEARED: assert property ((ce && enter_sd)
        |=> (pd_q == 8'h00) && (state_q == ST_SHUTDOWN))
        else $error("count not cleared on shutdown entry");

    AST_FLAGS_IDLE: assert property ((state_q != ST_ACQ)
        |-> (flag_q == '0) && !new_data_pin)
        else $error("new data shown while powered down");

    AST_DAC_OFF: assert property ((state_q == ST_SHUTDOWN)
        |-> dac_powerdown && !sample_strobe)
        else $error("converter active during shutdown");

    AST_DEPTH_MAX: assert property (avg_q <= AVG_MAX)
        else $error("depth above maximum");

    AST_HOLD_DATA: assert property ((state_q != ST_ACQ)
        |=> $stable(data_q))
        else $error("output words changed in shutdown");

    AST_UPDATE_FLAGS: assert property ((ce && upd && pd_q == 8'h00)
        |=> (flag_q == '1) && (data_q == $past(filt_data)))
        else $error("update did not refresh every word");

    AST_RECOVER_WAIT: assert property ((ce && tk.half_tick && remain_q == 8'h01
        && state_q == ST_SHUTDOWN) |=> (state_q == ST_RECOVER)
        && (recov_q == 32'(RECOVER_CYC - 1)))
        else $error("recovery wait not started");

    AST_NO_EARLY_WAKE: assert property ((state_q == ST_SHUTDOWN && !tk.half_tick)
        |=> (state_q == ST_SHUTDOWN))
        else $error("left shutdown without timeout");

    AST_RAW_ALARM: assert property ((ce && sample_strobe)
        |=> alarm_strobe && (alarm_data == $past(raw_data)))
        else $error("alarm path not fed raw sample");

    AST_PD_ZERO_IDLE: assert property ((state_q != ST_ACQ)
        |-> (pd_q == 8'h00))
        else $error("count nonzero while powered down");

    AST_RESTORE_NV: assert property ((ce && restore_q)
        |=> (period_q == $past(nv_period_cfg)) && !restore_q)
        else $error("period setting not restored");

    AST_WAKE: assert property ((ce && state_q == ST_RECOVER && recov_q == 32'h00000000)
        |=> (state_q == ST_ACQ))
        else $error("recovery did not end");

    AST_ENTRY_PINS: assert property ((ce && enter_sd)
        |=> dac_powerdown && !new_data_pin && (flag_q == '0))
        else $error("shutdown entry outputs wrong");

    AST_WORDS_ON_UPDATE: assert property (!(ce && upd)
        |=> $stable(data_q))
        else $error("output words changed without update");

    AST_PERIOD_RESTART: assert property ((wr_ok && !reg_addr[0] && wsel == SEL_PERIOD)
        |=> period_chg_q && (period_q == $past(reg_wdata)))
        else $error("period write not applied");

    AST_COUNT_WAIT: assert property ((ce && state_q == ST_ACQ && !upd)
        |=> (state_q == ST_ACQ))
        else $error("shutdown entered without update");

    AST_ZERO_RUNS: assert property ((ce && upd && pd_q == 8'h00)
        |=> (state_q == ST_ACQ))
        else $error("left acquisition with zero count");
endmodule

// [hw/srap_pkg.sv]
// constants shared by the acquisition pacing, averaging and shutdown logic
package srap_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SHORT_UNIT_NS = 122100;
    localparam int LONG_UNIT_NS = 3784000;
    localparam int HALF_SEC_NS = 500000000;
    localparam int RECOVER_NS = 2000000;
    localparam int SHORT_UNIT_CYC = SHORT_UNIT_NS / CLK_PERIOD_NS;
    localparam int LONG_UNIT_CYC = LONG_UNIT_NS / CLK_PERIOD_NS;
    localparam int HALF_SEC_CYC = HALF_SEC_NS / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_WORDS = 7;
    localparam int WORD_W = 16;
    localparam int AVG_LOG_MAX = 8;
    localparam logic [6:0] ADDR_PERIOD = 7'h36;
    localparam logic [6:0] ADDR_AVG = 7'h38;
    localparam logic [6:0] ADDR_PD = 7'h3a;
    localparam int TB_SEL_BIT = 7;
    localparam int CNT_MSB = 6;
    localparam int AVG_MSB = 3;
    localparam logic [7:0] PERIOD_RST = 8'h04;
    localparam logic [3:0] AVG_RST = 4'h4;
    localparam logic [3:0] AVG_MAX = 4'h8;
    localparam logic [7:0] PD_RST = 8'h00;
    typedef enum logic [2:0] {
        ST_ACQ = 3'b001,
        ST_SHUTDOWN = 3'b010,
        ST_RECOVER = 3'b100
    } srap_state_t;
    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_PERIOD = 2'h1,
        SEL_AVG = 2'h2,
        SEL_PD = 2'h3
    } srap_sel_t;
endpackage

// [hw/srap_tick_if.sv]
// pacing signals between the controller and the time base
`timescale 1ns/1ns
interface srap_tick_if;
    logic ce;
    logic restart;
    logic run;
    logic long_base;
    logic [6:0] period_count;
    logic period_tick;
    logic half_run;
    logic half_tick;
    modport ctrl (output ce, restart, run, long_base, period_count, half_run,
                  input period_tick, half_tick);
    modport tb (input ce, restart, run, long_base, period_count, half_run,
                output period_tick, half_tick);
endinterface

// [hw/srap_timebase.sv]
// sample period and half-second tick generator
`timescale 1ns/1ns
module srap_timebase #(
    parameter int LONG_UNIT_CYC = srap_pkg::LONG_UNIT_CYC,
    parameter int HALF_SEC_CYC = srap_pkg::HALF_SEC_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    srap_tick_if.tb tk
);
    import srap_pkg::*;

    logic [15:0] unit_q;
    logic [15:0] unit_last;
    logic [6:0] units_q;
    logic tick_q;
    logic [31:0] half_q;
    logic half_tick_q;

    assign unit_last = tk.long_base ? 16'(LONG_UNIT_CYC - 1) : 16'(SHORT_UNIT_CYC - 1);
    assign tk.period_tick = tick_q;
    assign tk.half_tick = half_tick_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            unit_q <= 16'h0000;
            units_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (tk.ce) begin
            tick_q <= 1'b0;
            if (!tk.run || tk.restart) begin
                unit_q <= 16'h0000;
                units_q <= 7'h00;
            end else if (unit_q == unit_last) begin
                unit_q <= 16'h0000;
                if (units_q == tk.period_count) begin
                    units_q <= 7'h00;
                    tick_q <= 1'b1;
                end else begin
                    units_q <= units_q + 7'h01;
                end
            end else begin
                unit_q <= unit_q + 16'h0001;
            end
        end
    end

    // shutdown clock only runs while powered down
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            half_q <= 32'h00000000;
            half_tick_q <= 1'b0;
        end else if (tk.ce) begin
            half_tick_q <= 1'b0;
            if (!tk.half_run) begin
                half_q <= 32'h00000000;
            end else if (half_q == 32'(HALF_SEC_CYC - 1)) begin
                half_q <= 32'h00000000;
                half_tick_q <= 1'b1;
            end else begin
                half_q <= half_q + 32'h00000001;
            end
        end
    end
endmodule

// [hw/srap_avg.sv]
// power-of-two moving average over all output words at once
`timescale 1ns/1ns
module srap_avg #(
    parameter int CH = srap_pkg::NUM_WORDS,
    parameter int W = srap_pkg::WORD_W,
    parameter int LOG_MAX = srap_pkg::AVG_LOG_MAX
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic restart,
    input wire logic [3:0] depth,
    input wire logic in_valid,
    input wire logic [CH*W-1:0] in_data,
    output logic out_valid,
    output logic [CH*W-1:0] out_data
);
    import srap_pkg::*;

    localparam int DEPTH = 1 << LOG_MAX;
    localparam int SW = W + LOG_MAX;

    logic [LOG_MAX-1:0] ptr_q;
    logic [LOG_MAX:0] fill_q;
    logic [LOG_MAX:0] taps;
    logic full;
    logic valid_q;

    assign taps = (LOG_MAX + 1)'(1) << depth;
    assign full = fill_q >= taps;
    assign out_valid = valid_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ptr_q <= '0;
            fill_q <= '0;
            valid_q <= 1'b0;
        end else if (ce) begin
            valid_q <= in_valid && !restart;
            if (restart) begin
                ptr_q <= '0;
                fill_q <= '0;
            end else if (in_valid) begin
                ptr_q <= ptr_q + 1'b1;
                if (!full) begin
                    fill_q <= fill_q + 1'b1;
                end
            end
        end
    end

    // one running sum per word, all sharing the same depth and pointer
    for (genvar c = 0; c < CH; c++) begin : g_ch
        logic signed [W-1:0] hist [DEPTH];
        logic signed [SW-1:0] sum_q;
        logic signed [SW-1:0] sum_d;
        logic signed [W-1:0] new_s;
        logic signed [W-1:0] old_s;
        logic [W-1:0] avg_q;

        assign new_s = in_data[c*W +: W];
        assign old_s = full ? hist[ptr_q - taps[LOG_MAX-1:0]] : '0;
        assign sum_d = sum_q + SW'(new_s) - SW'(old_s);
        assign out_data[c*W +: W] = avg_q;

        always_ff @(posedge ref_clk) begin
            if (ce && in_valid) begin
                hist[ptr_q] <= new_s;
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                sum_q <= '0;
                avg_q <= '0;
            end else if (ce) begin
                if (restart) begin
                    sum_q <= '0;
                end else if (in_valid) begin
                    sum_q <= sum_d;
                    avg_q <= W'(sum_d >>> depth);
                end
            end
        end
    end
endmodule

// [verif/srap_host.sv]
// host model that drives the register bus of the pacing controller
`timescale 1ns/1ns
module srap_host
    import srap_pkg::*;
(
    input wire logic ref_clk,
    output logic [6:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    output logic reg_rd_en
);
    initial begin
        reg_addr = 7'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
    end

    // a zero period count is never sent; the smallest legal count goes out instead
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= (a == ADDR_PERIOD && d[6:0] == 7'h00) ? (d | 8'h01) : d;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        // idle data must not look like the last byte
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [6:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
    endtask
endmodule

// [verif/sample_rate_average_powerdown_ctrl_test.sv]
// self-checking bench for the pacing, averaging and shutdown controller
`timescale 1ns/1ns
module sample_rate_average_powerdown_ctrl_test;
    import srap_pkg::*;
    localparam int LU = 40;
    localparam int HS = 50;
    localparam int RC = 20;
    logic ref_clk, nrst, reg_wr_en, reg_rd_en, new_data_pin, dac_powerdown, acquiring;
    logic sample_strobe, alarm_strobe;
    logic rd_d = 1'b0;
    logic al_d = 1'b0;
    logic al_d2 = 1'b0;
    logic ce = 1'b1;
    logic [6:0] word_read = 7'h00;
    logic [6:0] reg_addr, new_sample_flag;
    logic [7:0] reg_wdata, nv_period_cfg, sample_period_setting;
    logic [3:0] nv_avg_cfg, average_depth_setting;
    logic [15:0] reg_rd_data;
    logic [111:0] raw_data, alarm_data, out_data, keep;
    int error_cnt = 0;
    int n_checks = 0;
    int depth = 0;
    int cyc = 0;
    int n, t0;
    bit pd_pend = 0;
    int win[7][$];
    logic [15:0] rq[$];
    logic [111:0] aq[$], oq[$];
    logic [6:0] fq[$];

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    srap_host srap_host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));

    srap_ctrl #(.LONG_UNIT_CYC(LU), .HALF_SEC_CYC(HS), .RECOVER_CYC(RC)) srap_ctrl_i (
        .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .nv_period_cfg(nv_period_cfg), .nv_avg_cfg(nv_avg_cfg),
        .sample_period_setting(sample_period_setting),
        .average_depth_setting(average_depth_setting), .raw_data(raw_data),
        .sample_strobe(sample_strobe), .alarm_data(alarm_data), .alarm_strobe(alarm_strobe),
        .out_data(out_data), .new_sample_flag(new_sample_flag), .word_read(word_read),
        .new_data_pin(new_data_pin), .dac_powerdown(dac_powerdown), .acquiring(acquiring));

    task automatic chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // the filter window starts empty, so early outputs ramp up from zero
    task automatic restart(input int d);
        depth = d;
        for (int w = 0; w < 7; w++) begin
            win[w] = {};
            repeat (1 << d) win[w].push_back(0);
        end
    endtask

    task automatic wstrobe(input int lim);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (sample_strobe !== 1'b1 && n < lim);
        if (sample_strobe !== 1'b1) begin
            chk(1'b0, "no sample strobe");
            final_report();
        end
    endtask

    task automatic wacq(input logic lv, input int lim);
        n = 0;
        while (acquiring !== lv && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        if (acquiring !== lv) begin
            chk(1'b0, "state wait");
            final_report();
        end
    endtask

    task automatic meas(input int p);
        wstrobe(3000);
        wstrobe(3000);
        chk(n == p, "sample period");
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        rq.push_back(e);
        srap_host_i.rd(a);
    endtask

    // depth changes land well clear of a strobe so no sample is in flight
    task automatic set_depth(input logic [7:0] v);
        wstrobe(3000);
        repeat (4) @(posedge ref_clk);
        restart(v > 8 ? 8 : int'(v));
        srap_host_i.wr(ADDR_AVG, v);
        repeat (3) wstrobe(3000);
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (sample_strobe === 1'b1) begin
            logic [111:0] avg;
            int s;
            for (int w = 0; w < 7; w++) begin
                win[w].push_back(int'($signed(raw_data[16*w +: 16])));
                void'(win[w].pop_front());
                s = win[w].sum();
                avg[16*w +: 16] = 16'(s >>> depth);
            end
            aq.push_back(raw_data);
            oq.push_back(avg);
            fq.push_back(pd_pend ? 7'h00 : 7'h7f);
            pd_pend = 0;
            raw_data <= 112'({$urandom(), $urandom(), $urandom(), $urandom()});
        end
    end

    always @(posedge ref_clk) begin
        if (nrst !== 1'b1) begin
            aq.delete();
            oq.delete();
            fq.delete();
        end
        if (rd_d === 1'b1) begin
            chk(rq.size() > 0 && reg_rd_data === rq.pop_front(), "read data");
        end
        if (alarm_strobe === 1'b1) begin
            chk(aq.size() > 0 && alarm_data === aq.pop_front(), "raw capture");
        end
        // words and flags land two cycles after the raw capture
        if (al_d2 === 1'b1) begin
            chk(oq.size() > 0 && out_data === oq.pop_front(), "averages");
            chk(fq.size() > 0 && new_sample_flag === fq[0], "flags");
            chk(fq.size() > 0 && new_data_pin === (fq.pop_front() != 7'h00), "pin");
        end
        if (dac_powerdown === 1'b1) begin
            chk(sample_strobe === 1'b0 && new_data_pin === 1'b0, "activity off");
        end
        rd_d <= reg_rd_en;
        al_d <= alarm_strobe;
        al_d2 <= al_d;
    end

    initial begin
        void'($urandom(32'h20ad33e9));
        nrst = 1'b0;
        nv_period_cfg = 8'h81;
        nv_avg_cfg = 4'h0;
        raw_data = '0;
        repeat (20) @(posedge ref_clk);
        chk(sample_period_setting === PERIOD_RST, "period default");
        chk(average_depth_setting === AVG_RST, "depth default");
        restart(0);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(ADDR_PERIOD, 16'h0081);
        rd(ADDR_PD, 16'h0000);
        rd(7'h40, 16'h0000);
        meas(2 * LU);
        chk(acquiring === 1'b1, "continuous run");
        wstrobe(3000);
        repeat (4) @(posedge ref_clk);
        word_read <= 7'h05;
        @(posedge ref_clk);
        word_read <= 7'h7a;
        @(posedge ref_clk);
        chk(new_sample_flag === 7'h7a && new_data_pin === 1'b1, "partial read");
        word_read <= 7'h00;
        ce <= 1'b0;
        @(posedge ref_clk);
        chk(new_sample_flag === 7'h00 && new_data_pin === 1'b0, "all read");
        keep = out_data;
        repeat (99) @(posedge ref_clk);
        chk(sample_strobe === 1'b0 && out_data === keep, "frozen");
        ce <= 1'b1;
        wstrobe(3000);
        chk(n == 2 * LU - 6, "period frozen");
        srap_host_i.wr(ADDR_PERIOD, 8'h83);
        meas(4 * LU);
        srap_host_i.wr(ADDR_PERIOD, 8'h01);
        meas(2 * SHORT_UNIT_CYC);
        srap_host_i.wr(ADDR_PERIOD, 8'h81);
        set_depth(8'h09);
        rd(ADDR_AVG, 16'h0008);
        srap_host_i.wr(ADDR_AVG + 7'h01, 8'h03);
        rd(ADDR_AVG, 16'h0008);
        for (int d = 7; d >= 0; d--) set_depth(8'(d));
        wstrobe(3000);
        repeat (4) @(posedge ref_clk);
        pd_pend = 1;
        srap_host_i.wr(ADDR_PD, 8'h02);
        wacq(1'b0, 200);
        t0 = cyc;
        keep = out_data;
        chk(dac_powerdown === 1'b1, "converter off");
        rd(ADDR_PD, 16'h0000);
        srap_host_i.wr(ADDR_PD, 8'h05);
        wacq(1'b1, 400);
        n = cyc - t0;
        chk(n >= 2 * HS + RC + 1 && n <= 2 * HS + RC + 6, "shutdown length");
        chk(out_data === keep, "words held");
        rd(ADDR_PD, 16'h0000);
        rd(ADDR_PERIOD, 16'h0081);
        wstrobe(3000);
        wstrobe(3000);
        chk(n == 2 * LU, "period after wake");
        wstrobe(3000);
        repeat (4) @(posedge ref_clk);
        pd_pend = 1;
        srap_host_i.wr(ADDR_PD, 8'hff);
        wacq(1'b0, 200);
        repeat (10) @(posedge ref_clk);
        nv_period_cfg <= 8'h82;
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(acquiring === 1'b1 && dac_powerdown === 1'b0, "reset wakes");
        restart(0);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(ADDR_PERIOD, 16'h0082);
        rd(ADDR_PD, 16'h0000);
        meas(3 * LU);
        final_report();
    end
endmodule
